// ==== dv/sspr_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sspr_core_model (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic wait_req,
    input  wire logic wake_wfe,
    output var  logic wfe_active
);
    // core waits on request until the wake pulse
    always @(posedge aclk)
    begin
        if (!aresetn || wake_wfe)
            wfe_active <= 1'b0;
        else if (wait_req)
            wfe_active <= 1'b1;
    end
endmodule
`default_nettype wire

// ==== dv/sspr_regs_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module sspr_regs_checker (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       send_event,
    input wire logic       wfe_active,
    input wire logic       sleep_request,
    input wire logic       handler_return_thread,
    input wire logic [7:0] power_control_reg,
    input wire logic       deep_sleep_select,
    input wire logic       sleep_on_handler_exit,
    input wire logic       wake_wfe,
    input wire logic       deep_sleep_enter,
    input wire logic       power_down_request,
    input wire logic       sleep_on_exit_enter
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // wake pulse one cycle after its cause, or one cycle after the wait starts for an early event
    property p_sev; send_event && wfe_active |=> wake_wfe; endproperty
    a_sev: assert property (p_sev) else $error("no wake");
    property p_late; !wfe_active && send_event ##1 wfe_active |=> wake_wfe; endproperty
    a_late: assert property (p_late) else $error("event lost");
    // sleep kind follows the select bits
    property p_deep; sleep_request && deep_sleep_select |=> deep_sleep_enter; endproperty
    a_deep: assert property (p_deep) else $error("no deep");
    property p_light; sleep_request && !deep_sleep_select |=> !deep_sleep_enter; endproperty
    a_light: assert property (p_light) else $error("bad deep");
    property p_pdn;
        sleep_request && deep_sleep_select && |power_control_reg |=> power_down_request;
    endproperty
    a_pdn: assert property (p_pdn) else $error("no power down");
    property p_nopdn; sleep_request && !deep_sleep_select |=> !power_down_request; endproperty
    a_nopdn: assert property (p_nopdn) else $error("bad power down");
    property p_exit;
        handler_return_thread && sleep_on_handler_exit |=> sleep_on_exit_enter;
    endproperty
    a_exit: assert property (p_exit) else $error("no exit sleep");
    property p_noexit;
        !(handler_return_thread && sleep_on_handler_exit) |=> !sleep_on_exit_enter;
    endproperty
    a_noexit: assert property (p_noexit) else $error("bad exit sleep");
endmodule
bind sspr_regs sspr_regs_checker u_chk (.*);
`default_nettype wire

// ==== dv/system_sleep_priority_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module system_sleep_priority_regs_tb;
    logic        aclk, aresetn, wait_req, wfe_active, event_in, send_event, wake_wfe;
    logic        sleep_request, handler_return_thread, sleep_enter, deep_sleep_enter;
    logic        power_down_request, sleep_on_exit_enter, deep_sleep_select, aok, wok;
    logic        sleep_on_handler_exit, wake_on_pending_select, seen;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  svcall_priority, pendsv_priority, systick_handler_priority;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  power_control_reg;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, irq_pending, irq_enable, d, m [0:2];
    integer      seed, fail_count, checks, k, p;
    sspr_regs dut (.*);
    sspr_core_model core (.*);
    function [11:0] adr(input integer j);
        adr = j == 0 ? 12'h010 : j == 1 ? 12'h01C : 12'h020;
    endfunction
    function [31:0] msk(input integer j);
        msk = j == 0 ? 32'h00000016 : j == 1 ? 32'hC0000000 : 32'hC0C00000;
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    // bus write; each channel released once taken
    task wr(input [11:0] a, input [31:0] v);
    begin
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        @(negedge aclk);
        while (!s_axi_bvalid)
        begin
            aok = s_axi_awready;
            wok = s_axi_wready;
            @(posedge aclk);
            if (aok)
                s_axi_awvalid <= 1'b0;
            if (wok)
                s_axi_wvalid <= 1'b0;
            @(negedge aclk);
        end
        r = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    end
    endtask
    // bus read into d and r
    task rd(input [11:0] a);
    begin
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(negedge aclk);
        while (!s_axi_rvalid)
        begin
            aok = s_axi_arready;
            @(posedge aclk);
            if (aok)
                s_axi_arvalid <= 1'b0;
            @(negedge aclk);
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    end
    endtask
    // core waits, a source fires, wake pulse looked for
    // sev bit 0 is a send-event, bit 1 an external event
    task wk(input early, input [31:0] pend, input [31:0] en, input [1:0] sev, input exp);
    begin
        @(posedge aclk);
        irq_enable <= en;
        wait_req <= !early;
        @(posedge aclk);
        wait_req <= early;
        irq_pending <= pend;
        send_event <= sev[0];
        event_in <= sev[1];
        @(posedge aclk);
        wait_req <= 1'b0;
        send_event <= 1'b0;
        event_in <= 1'b0;
        seen = 1'b0;
        repeat (4) @(negedge aclk) seen = seen | wake_wfe;
        chk(seen, exp);
        @(posedge aclk);
        irq_pending <= 32'h0;
    end
    endtask
    task wrap_up;
    begin
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    initial
        forever #5 aclk = ~aclk;
    initial
    begin
        #200000;
        fail_count = fail_count + 1;
        wrap_up;
    end
    initial
    begin
        seed = 16039;
        fail_count = 0;
        checks = 0;
        aclk = 1'b0;
        aresetn = 1'b0;
        {wait_req, event_in, send_event, sleep_request, handler_return_thread} = 5'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, irq_pending, irq_enable} = 120'h0;
        s_axi_wstrb = 4'hF;
        power_control_reg = 8'h00;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, then random words read back through the mask
        for (k = 0; k < 15; k = k + 1)
        begin
            if (k > 2)
                wr(adr(k % 3), $random(seed));
            m[k % 3] = k > 2 ? s_axi_wdata & msk(k % 3) : 32'h0;
            rd(adr(k % 3));
            chk(d, m[k % 3]);
            chk(r, 2'h0);
        end
        // field outputs mirror the last words written
        chk(svcall_priority, m[1][31:30]);
        chk(pendsv_priority, m[2][23:22]);
        chk(systick_handler_priority, m[2][31:30]);
        chk(wake_on_pending_select, m[0][4]);
        chk({deep_sleep_select, sleep_on_handler_exit}, m[0][2:1]);
        // a write with no byte lanes enabled leaves the word alone
        s_axi_wstrb <= 4'h0;
        wr(12'h020, 32'hFFFFFFFF);
        chk(r, 2'h0);
        s_axi_wstrb <= 4'hF;
        rd(12'h020);
        chk(d, m[2]);
        wr(12'h014, 32'hFFFFFFFF);
        chk(r, 2'h2);
        rd(12'h014);
        chk(d, 32'h0);
        chk(r, 2'h2);
        // each sleep mode with a sleep and a handler return
        for (k = 0; k < 4; k = k + 1)
        begin
            wr(12'h010, k * 2);
            @(posedge aclk);
            power_control_reg <= k == 2 ? 8'h00 : $random(seed) | 8'h01;
            sleep_request <= 1'b1;
            handler_return_thread <= 1'b1;
            @(posedge aclk);
            sleep_request <= 1'b0;
            handler_return_thread <= 1'b0;
            @(negedge aclk);
            chk({deep_sleep_select, sleep_on_handler_exit, deep_sleep_enter,
                power_down_request, sleep_on_exit_enter},
                {k[1], k[0], k[1], k[1] & |power_control_reg, k[0]});
            chk(sleep_enter, !k[1]);
        end
        p = 1 << ($unsigned($random(seed)) % 32);
        wk(0, p, 32'h0, 2'h0, 0);
        wk(0, p, p, 2'h0, 1);
        wk(0, 32'h0, 32'h0, 2'h2, 1);
        wr(12'h010, 32'h00000010);
        chk(wake_on_pending_select, 1'b1);
        wk(0, p, 32'h0, 2'h0, 1);
        wk(1, p, 32'h0, 2'h0, 1);
        wk(0, 32'h0, 32'h0, 2'h1, 1);
        wk(1, 32'h0, 32'h0, 2'h1, 1);
        wrap_up;
    end
endmodule
`default_nettype wire

// ==== logic/sspr_defines.vh ====
`ifndef SSPR_DEFINES_VH
`define SSPR_DEFINES_VH

// register byte offsets
`define SSPR_ADDR_SLEEP_CTRL    12'h010
`define SSPR_ADDR_PRIO_TWO      12'h01C
`define SSPR_ADDR_PRIO_THREE    12'h020

// sleep control field positions
`define SSPR_BIT_SLEEP_EXIT     1
`define SSPR_BIT_DEEP_SLEEP     2
`define SSPR_BIT_WAKE_PEND      4

// priority field positions (low bit of each 2-bit field)
`define SSPR_POS_SVCALL         30
`define SSPR_POS_PENDSV         22
`define SSPR_POS_SYSTICK        30

// reset values
`define SSPR_RST_SLEEP_CTRL     32'h00000000
`define SSPR_RST_PRIO_TWO       32'h00000000
`define SSPR_RST_PRIO_THREE     32'h00000000

// bus responses
`define SSPR_RESP_OKAY          2'h0
`define SSPR_RESP_SLVERR        2'h2

`endif

// ==== logic/sspr_regs.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sspr_defines.vh"

// What this block does
// - bit clear: only enabled interrupts or events wake
// - bit set: any pending interrupt also wakes
// - inactive-to-pending edge counts as wake event
// - early events latched; next wait completes immediately
// - send-event instruction wakes a waiting core
// - deep-sleep bit chooses sleep or deep sleep
// - deep-sleep bit combines with power control register
// - sleep-on-exit lets core sleep after handler return
// - svcall priority in handler_priority_two bits 31:30
// - pendsv priority in handler_priority_three bits 23:22
// - systick priority in handler_priority_three bits 31:30
module sspr_regs #(
    parameter N_IRQ = 32
)(
    input  wire              aclk,
    input  wire              aresetn,
    input  wire [11:0]       s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [11:0]       s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire [N_IRQ-1:0]  irq_pending,
    input  wire [N_IRQ-1:0]  irq_enable,
    input  wire              event_in,
    input  wire              send_event,
    input  wire              wfe_active,
    input  wire              sleep_request,
    input  wire              handler_return_thread,
    input  wire [7:0]        power_control_reg,
    output reg               wake_wfe,
    output reg               sleep_enter,
    output reg               deep_sleep_enter,
    output reg               power_down_request,
    output reg               sleep_on_exit_enter,
    output wire              deep_sleep_select,
    output wire              sleep_on_handler_exit,
    output wire              wake_on_pending_select,
    output wire [1:0]        svcall_priority,
    output wire [1:0]        pendsv_priority,
    output wire [1:0]        systick_handler_priority
);

    // stored fields; reserved bits have no storage
    reg              sleep_exit;
    reg              deep_sel;
    reg              wake_pend;
    reg  [1:0]       prio_svc;
    reg  [1:0]       prio_psv;
    reg  [1:0]       prio_tick;
    // write beats held until both have arrived
    reg  [11:0]      aw_addr;
    reg              aw_held;
    reg  [31:0]      w_data;
    reg  [3:0]       w_strb;
    reg              w_held;
    // wake tracking
    reg  [N_IRQ-1:0] pend_prev;
    reg              event_latch;
    reg              wake_source;
    // read mux results
    reg  [31:0]      next_rdata;
    reg  [1:0]       next_rresp;

    // reset images of the three words
    localparam [31:0] rst_sleep_word = `SSPR_RST_SLEEP_CTRL;
    localparam [31:0] rst_two_word   = `SSPR_RST_PRIO_TWO;
    localparam [31:0] rst_three_word = `SSPR_RST_PRIO_THREE;

    // handshake and edge helpers
    wire             do_write;
    wire [N_IRQ-1:0] pend_rise;

    // mapped-register test for the write response decode
    function is_mapped;
        input [11:0] addr;
        begin
            is_mapped = (addr == `SSPR_ADDR_SLEEP_CTRL) ||
                        (addr == `SSPR_ADDR_PRIO_TWO) ||
                        (addr == `SSPR_ADDR_PRIO_THREE);
        end
    endfunction

    // readies low while a beat is held or a response waits
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;

    // field values straight to the core
    assign deep_sleep_select        = deep_sel;
    assign sleep_on_handler_exit    = sleep_exit;
    assign wake_on_pending_select   = wake_pend;
    assign svcall_priority          = prio_svc;
    assign pendsv_priority          = prio_psv;
    assign systick_handler_priority = prio_tick;

    // write channel capture and register update
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 12'h000;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SSPR_RESP_OKAY;
            // fields take their reset images
            sleep_exit   <= rst_sleep_word[`SSPR_BIT_SLEEP_EXIT];
            deep_sel     <= rst_sleep_word[`SSPR_BIT_DEEP_SLEEP];
            wake_pend    <= rst_sleep_word[`SSPR_BIT_WAKE_PEND];
            prio_svc     <= rst_two_word[`SSPR_POS_SVCALL +: 2];
            prio_psv     <= rst_three_word[`SSPR_POS_PENDSV +: 2];
            prio_tick    <= rst_three_word[`SSPR_POS_SYSTICK +: 2];
        end
        else
        begin
            // address and data beats may arrive in either order
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
            end
            // response rises with the field update, so a
            // read after bvalid never sees the old word
            if (do_write)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped({aw_addr[11:2], 2'b00}) ?
                                `SSPR_RESP_OKAY : `SSPR_RESP_SLVERR;
                if ({aw_addr[11:2], 2'b00} == `SSPR_ADDR_SLEEP_CTRL && w_strb[0])
                begin
                    sleep_exit <= w_data[`SSPR_BIT_SLEEP_EXIT];
                    deep_sel   <= w_data[`SSPR_BIT_DEEP_SLEEP];
                    wake_pend  <= w_data[`SSPR_BIT_WAKE_PEND];
                end
                if ({aw_addr[11:2], 2'b00} == `SSPR_ADDR_PRIO_TWO && w_strb[3])
                    prio_svc <= w_data[`SSPR_POS_SVCALL +: 2];
                if ({aw_addr[11:2], 2'b00} == `SSPR_ADDR_PRIO_THREE && w_strb[2])
                    prio_psv <= w_data[`SSPR_POS_PENDSV +: 2];
                if ({aw_addr[11:2], 2'b00} == `SSPR_ADDR_PRIO_THREE && w_strb[3])
                    prio_tick <= w_data[`SSPR_POS_SYSTICK +: 2];
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // read data mux
    always @*
    begin
        // defaults: zero data, okay response
        next_rdata = 32'h00000000;
        next_rresp = `SSPR_RESP_OKAY;
        case ({s_axi_araddr[11:2], 2'b00})
            `SSPR_ADDR_SLEEP_CTRL:
            begin
                next_rdata[`SSPR_BIT_SLEEP_EXIT] = sleep_exit;
                next_rdata[`SSPR_BIT_DEEP_SLEEP] = deep_sel;
                next_rdata[`SSPR_BIT_WAKE_PEND]  = wake_pend;
            end
            `SSPR_ADDR_PRIO_TWO:
                next_rdata[`SSPR_POS_SVCALL +: 2] = prio_svc;
            `SSPR_ADDR_PRIO_THREE:
            begin
                next_rdata[`SSPR_POS_PENDSV +: 2]  = prio_psv;
                next_rdata[`SSPR_POS_SYSTICK +: 2] = prio_tick;
            end
            // unmapped word: error, zero data
            default:
                next_rresp = `SSPR_RESP_SLVERR;
        endcase
    end

    // read channel
    // rdata captured at the address handshake and
    // held until the master takes it
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `SSPR_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // pending bits that went high this cycle
    assign pend_rise = irq_pending & ~pend_prev;

    // wake source selection
    // edges, not levels: a bit that stays pending
    // must not wake the core again every cycle
    always @*
    begin
        wake_source = event_in || (|(pend_rise & irq_enable));
        if (wake_pend)
            wake_source = wake_source || (|pend_rise);
        wake_source = wake_source || send_event;
    end

    // a new event in the consuming cycle joins
    // that wake, so none is lost
    // event latch and wake pulse
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pend_prev   <= {N_IRQ{1'b0}};
            event_latch <= 1'b0;
            wake_wfe    <= 1'b0;
        end
        else
        begin
            // edge history follows the pins every cycle
            pend_prev <= irq_pending;
            wake_wfe  <= 1'b0;
            if (wfe_active && (event_latch || wake_source))
            begin
                wake_wfe    <= 1'b1;
                event_latch <= 1'b0;
            end
            else if (wake_source)
                event_latch <= 1'b1;
        end
    end

    // low-power entry outputs
    // one-cycle pulses naming the mode; the core
    // itself decides when to stop its clock
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sleep_enter         <= 1'b0;
            deep_sleep_enter    <= 1'b0;
            power_down_request  <= 1'b0;
            sleep_on_exit_enter <= 1'b0;
        end
        else
        begin
            sleep_on_exit_enter <= handler_return_thread && sleep_exit;
            sleep_enter      <= (sleep_request ||
                                 (handler_return_thread && sleep_exit)) && !deep_sel;
            deep_sleep_enter <= (sleep_request ||
                                 (handler_return_thread && sleep_exit)) && deep_sel;
            // deeper states need power control setting
            power_down_request <= (sleep_request ||
                                   (handler_return_thread && sleep_exit)) &&
                                  deep_sel && (|power_control_reg);
        end
    end

endmodule
`default_nettype wire
